// ===== shared/pfq_pkg.sv
// Constants for the programmable equaliser configuration block.
// Assumes a 12-bit register address space and 24-bit register data.
package pfq_pkg;
    // ==========================================================
    // Widths
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 24;
    localparam int SAMP_W   = 12;
    localparam int COEF_W   = 18;
    localparam int ACC_W    = 36;
    localparam int NTAPS    = 9;
    localparam int NCOEF    = 18;
    localparam int CTR_TAP  = 4;
    localparam int FRAC_W   = 16;
    localparam int SIDE_W   = 12;
    // ==========================================================
    // Register offsets
    localparam logic [11:0] ADDR_CFG = 12'h400;
    localparam logic [11:0] ADDR_COEF [NCOEF] = '{
        12'h418, 12'h41a, 12'h41c, 12'h41e, 12'h420,
        12'h424, 12'h426, 12'h428, 12'h42a,
        12'h430, 12'h432, 12'h434, 12'h436, 12'h438,
        12'h43c, 12'h43e, 12'h440, 12'h442};
    // ==========================================================
    // Configuration fields
    localparam int MODE_LSB  = 0;
    localparam int SCW_LSB   = 2;
    localparam int MERGE_BIT = 5;
    localparam int SHARE_BIT = 6;
    localparam logic [1:0] MODE_ON  = 2'h2;
    localparam logic [2:0] SCW_MAX  = 3'h6;
    // ==========================================================
    // Coefficient register layout and resets
    localparam int SIDE_MSB = 11;
    localparam int CTR_MSB  = 17;
    localparam logic [23:0] SIDE_MASK = 24'h00ffff;
    localparam logic [23:0] CTR_MASK  = 24'hffffff;
    localparam logic [7:0]  CFG_RST   = 8'h00;
    localparam logic [23:0] COEF_RST  = 24'h000000;
    localparam logic [11:0] SAMP_MAX  = 12'h7ff;
    localparam logic [11:0] SAMP_MIN  = 12'h800;
endpackage

// ===== rtl/pfq_equalizer.sv
// Programmable nine-tap equaliser: configuration, coefficient store, filter.
// Assumes samples and register port share clk_in; no synchronisers needed.
// Functional notes
// (R1) Share bit: B filter uses A coefficients
// (R2) Merge bit: one filter, interleaved stream
// (R3) Host sets merge for single-channel operation
// (R4) Side LSB weight is 2^(field-16)
// (R5) Center tap ignores side weight field
// (R6) Mode 0 disables, mode 2 enables
// (R7) Host loads coefficients when enabling filter
// (R8) Host reconfigures only with link disabled
// (R9) Side taps: 12-bit signed, upper reserved
// (R10) First A register drives tap zero
// (R11) Coefficient MSB reads back as zero
// (R12) Config register resets to all zeros
// (R13) Nine taps, 18-bit center tap
// (R14) Disabled passes samples; enabled sums taps
// (R15) Reserved bits never affect filtering
`timescale 1ns/10ps
module pfq_equalizer
    import pfq_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic              wr_strobe_in,
    input  wire logic              rd_strobe_in,
    output logic      [DATA_W-1:0] rd_data_out,
    input  wire logic [SAMP_W-1:0] sample_a_in,
    input  wire logic [SAMP_W-1:0] sample_b_in,
    input  wire logic              sample_valid_in,
    input  wire logic              serial_link_enable_in,
    output logic      [SAMP_W-1:0] filt_a_out,
    output logic      [SAMP_W-1:0] filt_b_out,
    output logic                   filt_valid_out
);
    // ==========================================================
    // Configuration register
    logic [7:0]        cfg_ff;
    logic [DATA_W-1:0] coef_ff [NCOEF];
    logic              filt_en;
    logic              merge_en;
    logic              share_en;
    logic [2:0]        scw_eff;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_ff <= CFG_RST;                                   // [R12]
        end else if (wr_strobe_in && addr_in == ADDR_CFG) begin
            cfg_ff <= wr_data_in[7:0];
        end
    end

    // Reserved encodings 1 and 3 behave as disabled
    assign filt_en  = (cfg_ff[MODE_LSB+1:MODE_LSB] == MODE_ON);  // [R6] [R15]
    assign merge_en = cfg_ff[MERGE_BIT];                         // [R2]
    assign share_en = cfg_ff[SHARE_BIT];                         // [R1]
    // Out-of-range weight is clamped rather than wrapping the shift
    assign scw_eff  = (cfg_ff[SCW_LSB+2:SCW_LSB] > SCW_MAX) ?
                      SCW_MAX : cfg_ff[SCW_LSB+2:SCW_LSB];       // [R4]

    // ==========================================================
    // Coefficient store: entries 0..8 are A, 9..17 are B
    generate
        for (genvar e = 0; e < NCOEF; e++) begin : g_coef
            localparam logic [23:0] MASK =
                ((e % NTAPS) == CTR_TAP) ? CTR_MASK : SIDE_MASK; // [R13]
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    coef_ff[e] <= COEF_RST;
                end else if (wr_strobe_in && addr_in == ADDR_COEF[e]) begin
                    coef_ff[e] <= wr_data_in & MASK;             // [R9]
                end
            end
        end
    endgenerate

    // ==========================================================
    // Register read port
    logic [DATA_W-1:0] nxt_rd_data;
    logic [DATA_W-1:0] rd_data_ff;

    always_comb begin
        nxt_rd_data = '0;
        if (rd_strobe_in) begin
            if (addr_in == ADDR_CFG) begin
                nxt_rd_data = {16'h0000, cfg_ff};
            end
            for (int e = 0; e < NCOEF; e++) begin
                if (addr_in == ADDR_COEF[e]) begin
                    nxt_rd_data = coef_ff[e];
                    // Coefficient sign bit is lost on readback
                    if ((e % NTAPS) == CTR_TAP) begin
                        nxt_rd_data[CTR_MSB] = 1'b0;             // [R11]
                    end else begin
                        nxt_rd_data[SIDE_MSB] = 1'b0;            // [R11]
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end
    assign rd_data_out = rd_data_ff;

    // ==========================================================
    // Sample histories, newest at index 0
    logic signed [SAMP_W-1:0] ha_ff [NTAPS];
    logic signed [SAMP_W-1:0] hb_ff [NTAPS];
    logic                     vld_d_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            vld_d_ff <= 1'b0;
            for (int k = 0; k < NTAPS; k++) begin
                ha_ff[k] <= '0;
                hb_ff[k] <= '0;
            end
        end else begin
            vld_d_ff <= sample_valid_in;
            if (sample_valid_in) begin
                ha_ff[0] <= sample_a_in;
                hb_ff[0] <= sample_b_in;
                for (int k = 1; k < NTAPS; k++) begin
                    ha_ff[k] <= ha_ff[k-1];
                    hb_ff[k] <= hb_ff[k-1];
                end
            end
        end
    end

    // ==========================================================
    // Per-tap windows, coefficients and products
    // Merged stream order, newest first: b[n], a[n], b[n-1], a[n-1]...
    logic signed [SAMP_W-1:0] win_a  [NTAPS];
    logic signed [SAMP_W-1:0] win_b  [NTAPS];
    logic signed [COEF_W-1:0] cuse_a [NTAPS];
    logic signed [COEF_W-1:0] cuse_b [NTAPS];
    logic signed [ACC_W-1:0]  prod_a [NTAPS];
    logic signed [ACC_W-1:0]  prod_b [NTAPS];

    generate
        for (genvar k = 0; k < NTAPS; k++) begin : g_tap
            localparam int EV = k / 2;
            localparam int OD = (k + 1) / 2;
            logic signed [COEF_W-1:0] ca;
            logic signed [COEF_W-1:0] cb;
            logic signed [29:0]       ma;
            logic signed [29:0]       mb;
            if (k % 2 == 0) begin : g_even
                assign win_a[k] = merge_en ? ha_ff[EV] : ha_ff[k]; // [R2]
                assign win_b[k] = merge_en ? hb_ff[EV] : hb_ff[k]; // [R2]
            end else begin : g_odd
                assign win_a[k] = merge_en ? hb_ff[OD] : ha_ff[k]; // [R2]
                assign win_b[k] = merge_en ? ha_ff[EV] : hb_ff[k]; // [R2]
            end
            if (k == CTR_TAP) begin : g_ctr
                assign ca = coef_ff[k][CTR_MSB:0];                 // [R13]
                assign cb = coef_ff[k+NTAPS][CTR_MSB:0];
            end else begin : g_side
                assign ca = {{(COEF_W-SIDE_W){coef_ff[k][SIDE_MSB]}},
                             coef_ff[k][SIDE_MSB:0]};              // [R9]
                assign cb = {{(COEF_W-SIDE_W){coef_ff[k+NTAPS][SIDE_MSB]}},
                             coef_ff[k+NTAPS][SIDE_MSB:0]};
            end
            assign cuse_a[k] = ca;                                 // [R10]
            assign cuse_b[k] = (share_en || merge_en) ? ca : cb;   // [R1]
            assign ma = win_a[k] * cuse_a[k];
            assign mb = win_b[k] * cuse_b[k];
            if (k == CTR_TAP) begin : g_pc
                assign prod_a[k] = {{6{ma[29]}}, ma};              // [R5]
                assign prod_b[k] = {{6{mb[29]}}, mb};              // [R5]
            end else begin : g_ps
                assign prod_a[k] = {{6{ma[29]}}, ma} <<< scw_eff;  // [R4]
                assign prod_b[k] = {{6{mb[29]}}, mb} <<< scw_eff;  // [R4]
            end
        end
    endgenerate

    // ==========================================================
    // Accumulate, scale and saturate
    logic signed [ACC_W-1:0] acc_a;
    logic signed [ACC_W-1:0] acc_b;
    logic        [SAMP_W-1:0] nxt_filt_a;
    logic        [SAMP_W-1:0] nxt_filt_b;

    function automatic logic [SAMP_W-1:0] sat_f(
        input logic signed [ACC_W-1:0] acc
    );
        logic signed [ACC_W-1:0] r;
        r = acc >>> FRAC_W;
        if (r > $signed({{(ACC_W-SAMP_W){1'b0}}, SAMP_MAX})) begin
            sat_f = SAMP_MAX;
        end else if (r < $signed({{(ACC_W-SAMP_W){1'b1}}, SAMP_MIN})) begin
            sat_f = SAMP_MIN;
        end else begin
            sat_f = r[SAMP_W-1:0];
        end
    endfunction

    always_comb begin
        acc_a = '0;
        acc_b = '0;
        for (int k = 0; k < NTAPS; k++) begin
            acc_a = acc_a + prod_a[k];                           // [R14]
            acc_b = acc_b + prod_b[k];
        end
        // Disabled path keeps the same two-cycle latency
        nxt_filt_a = filt_en ? sat_f(acc_a) : ha_ff[0];          // [R14]
        nxt_filt_b = filt_en ? sat_f(acc_b) : hb_ff[0];          // [R14]
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            filt_a_out     <= '0;
            filt_b_out     <= '0;
            filt_valid_out <= 1'b0;
        end else begin
            filt_valid_out <= vld_d_ff;
            if (vld_d_ff) begin
                filt_a_out <= nxt_filt_a;
                filt_b_out <= nxt_filt_b;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb_chk @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic hist_same;
    always_comb begin
        hist_same = 1'b1;
        for (int k = 0; k < NTAPS; k++) begin
            if (ha_ff[k] != hb_ff[k]) begin
                hist_same = 1'b0;
            end
        end
    end

    sequence s_cfg_wr;
        wr_strobe_in && addr_in == ADDR_CFG;
    endsequence

    sequence s_cfg_rd;
        rd_strobe_in && addr_in == ADDR_CFG;
    endsequence

    sequence s_pass_in;
        sample_valid_in && !filt_en ##1 !filt_en;
    endsequence

    cfg_reset_zero_a: assert property (disable iff (1'b0) // [R12]
        rst_in |=> cfg_ff == CFG_RST && !filt_en)
        else $error("config not zero after reset");
    mode_decode_a: assert property ( // [R6]
        s_cfg_wr |=> filt_en == ($past(wr_data_in[1:0]) == 2'h2))
        else $error("mode decode wrong");
    pass_through_a: assert property ( // [R14]
        s_pass_in |=> filt_valid_out && filt_a_out == $past(sample_a_in, 2)
            && filt_b_out == $past(sample_b_in, 2))
        else $error("disabled filter altered samples");
    valid_latency_a: assert property ( // [R14]
        sample_valid_in |-> ##2 filt_valid_out)
        else $error("output valid not two cycles after input");
    share_equal_a: assert property ( // [R1]
        vld_d_ff && filt_en && share_en && hist_same
            |=> filt_a_out == filt_b_out)
        else $error("shared coefficients give unequal outputs");
    merge_order_a: assert property ( // [R2]
        merge_en |-> win_b[1] == ha_ff[0] && win_a[1] == hb_ff[1]
            && win_b[8] == hb_ff[4])
        else $error("merged window order wrong");
    coef_store_a: assert property ( // [R9]
        wr_strobe_in && addr_in == 12'h418 |=>
            cuse_a[0] == $signed($past(wr_data_in[11:0]))
            && coef_ff[0][23:16] == 8'h00)
        else $error("first tap coefficient not stored");
    rd_msb_zero_a: assert property ( // [R11]
        rd_strobe_in && addr_in == 12'h418 |=> rd_data_out[11] == 1'b0
            && rd_data_out[10:0] == $past(coef_ff[0][10:0]))
        else $error("coefficient readback msb not zero");
    weight_clamp_a: assert property ( // [R4]
        scw_eff <= 3'h6 && (cfg_ff[4:2] > 3'h6 || scw_eff == cfg_ff[4:2]))
        else $error("side weight out of range");
    center_fixed_a: assert property ( // [R5]
        $changed(scw_eff) && $stable(win_a[4]) && $stable(cuse_a[4])
            |-> $stable(prod_a[4]))
        else $error("center tap scaled by side weight");

    // ==========================================================
    // Register port checks
    cfg_readback_a: assert property ( // [R15]
        s_cfg_rd |=> rd_data_out == {16'h0000, $past(cfg_ff)})
        else $error("config readback differs from stored value");
    rd_idle_zero_a: assert property ( // [R11]
        !rd_strobe_in |=> rd_data_out == '0)
        else $error("read data not zero outside read");
    reserved_inert_a: assert property ( // [R15]
        s_cfg_wr ##1 $stable(cfg_ff[6:0]) |-> $stable(filt_en)
            && $stable(merge_en) && $stable(scw_eff)
            && $stable(share_en))
        else $error("reserved config bit changed filter");
    coef_reset_a: assert property (disable iff (1'b0) // [R12]
        rst_in |=> coef_ff[0] == COEF_RST && coef_ff[CTR_TAP] == COEF_RST)
        else $error("coefficients not zero after reset");

    // ==========================================================
    // Coefficient selection checks, one set per tap
    // Checked against stored words so a broken select shows up
    generate
        for (genvar k = 0; k < NTAPS; k++) begin : g_chk
            share_select_a: assert property ( // [R1]
                (share_en || merge_en) |-> cuse_b[k] == cuse_a[k])
                else $error("B taps not using A coefficients");
            if (k == CTR_TAP) begin : g_cc
                ctr_width_a: assert property ( // [R13]
                    cuse_a[k] == $signed(coef_ff[k][CTR_MSB:0]))
                    else $error("center tap not full width");
                ctr_own_a: assert property ( // [R1]
                    !share_en && !merge_en |->
                        cuse_b[k] == $signed(coef_ff[k+NTAPS][CTR_MSB:0]))
                    else $error("B center tap not own coefficient");
            end else begin : g_cs
                side_width_a: assert property ( // [R9]
                    cuse_a[k] == $signed(coef_ff[k][SIDE_MSB:0]))
                    else $error("side tap not twelve bit signed");
                side_own_a: assert property ( // [R1]
                    !share_en && !merge_en |->
                        cuse_b[k] == $signed(coef_ff[k+NTAPS][SIDE_MSB:0]))
                    else $error("B side tap not own coefficient");
            end
        end
    endgenerate
endmodule // pfq_equalizer

// ===== test/pfq_stream_src.sv
// Converter-side model: bursts of sample pairs into the equaliser.
// Assumes clk_in and rst_in are shared with the equaliser.
`timescale 1ns/10ps
module pfq_stream_src
    import pfq_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              start_in,
    input  wire logic [SAMP_W-1:0] a_val_in,
    input  wire logic [SAMP_W-1:0] b_val_in,
    output logic      [SAMP_W-1:0] sample_a_out,
    output logic      [SAMP_W-1:0] sample_b_out,
    output logic                   sample_valid_out,
    output logic                   link_enable_out
);
    // ==========================================================
    // Burst of 12 pairs, enough to flush any nine-tap window
    logic [3:0] left_ff;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            left_ff <= 4'h0;
        end else if (start_in) begin
            left_ff <= 4'hc;
        end else if (left_ff != 4'h0) begin
            left_ff <= left_ff - 4'h1;
        end
    end
    assign sample_valid_out = (left_ff != 4'h0);
    // Idle lines show inverse data, so stale values never pass
    assign sample_a_out = sample_valid_out ? a_val_in : ~a_val_in;
    assign sample_b_out = sample_valid_out ? b_val_in : ~b_val_in;
    // Link only up while streaming; host configures with it low
    assign link_enable_out = sample_valid_out;
endmodule // pfq_stream_src

// ===== test/programmable_fir_equalizer_cfg_test.sv
// Self-checking bench for the equaliser: register port and filter path.
// Assumes one 50 MHz clock and the stream model beside the design.
`timescale 1ns/10ps
module programmable_fir_equalizer_cfg_test
    import pfq_pkg::*;
;
    logic              clk_in = 1'b0;
    logic              rst_in = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr_s = 1'b0;
    logic              rd_s = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [SAMP_W-1:0] sa, sb, fa, fb, av = '0, bv = '0;
    logic              sv, fv, link, start = 1'b0;
    int                failures = 0;
    int                checked = 0;
    int                cycles = 0;
    int                vld_seen = 0;
    // ==========================================================
    // Clock, timeout
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (fv === 1'b1) begin
            vld_seen++;
        end
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
    pfq_equalizer DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_strobe_in(wr_s), .rd_strobe_in(rd_s),
        .rd_data_out(rdata), .sample_a_in(sa), .sample_b_in(sb),
        .sample_valid_in(sv), .serial_link_enable_in(link),
        .filt_a_out(fa), .filt_b_out(fb), .filt_valid_out(fv));
    pfq_stream_src src (.clk_in(clk_in), .rst_in(rst_in), .start_in(start),
        .a_val_in(av), .b_val_in(bv), .sample_a_out(sa),
        .sample_b_out(sb), .sample_valid_out(sv), .link_enable_out(link));
    // ==========================================================
    // Tasks
    task automatic chk_reg(input string n, input logic [23:0] e);
        checked++;
        if (rdata !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, rdata);
        end
    endtask
    task automatic chk_samp(input string n, input logic [11:0] e,
                            input logic [11:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [23:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [23:0] e);
        @(posedge clk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        #1;
        chk_reg("rd_data_out", e);
    endtask
    // Burst of constant pairs, then wait out the 2-cycle latency
    task automatic run(input logic [11:0] a, input logic [11:0] b);
        @(posedge clk_in);
        vld_seen = 0;
        av <= a;
        bv <= b;
        start <= 1'b1;
        @(posedge clk_in);
        start <= 1'b0;
        #1;
        while (sv === 1'b1) @(posedge clk_in);
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(ADDR_CFG, 24'h000000);
        rd(ADDR_COEF[0], 24'h000000);
        wr(12'h7fc, 24'h0000ff);
        rd(12'h7fc, 24'h000000);
        $display("test reset done");
        wr(ADDR_CFG, 24'h0000f6);
        rd(ADDR_CFG, 24'h0000f6);
        wr(ADDR_COEF[0], 24'h00fabc);
        rd(ADDR_COEF[0], 24'h00f2bc);
        wr(ADDR_COEF[0], 24'h123456);
        rd(ADDR_COEF[0], 24'h003456);
        $display("test access done");
        wr(ADDR_CFG, 24'h000000);
        run(12'h123, 12'h456);
        chk_samp("filt_a_out", 12'h123, fa);
        chk_samp("filt_b_out", 12'h456, fb);
        chk_samp("filt_valid_out", 12'h00c, 12'(vld_seen));
        $display("test bypass done");
        wr(ADDR_COEF[0], 24'h000400);
        for (int s = 0; s <= 6; s++) begin
            wr(ADDR_CFG, 24'(s << 2) | 24'h2);
            run(12'h100, 12'h100);
            chk_samp("filt_a_out", 12'(4 << s), fa);
            chk_samp("filt_b_out", 12'h000, fb);
        end
        $display("test weight done");
        wr(ADDR_COEF[0], 24'h00fc00);
        rd(ADDR_COEF[0], 24'h00f400);
        wr(ADDR_CFG, 24'h000002);
        run(12'h100, 12'h100);
        chk_samp("filt_a_out", 12'hffc, fa);
        $display("test sign done");
        wr(ADDR_COEF[0], 24'h000000);
        wr(ADDR_COEF[4], 24'h030000);
        rd(ADDR_COEF[4], 24'h010000);
        wr(ADDR_CFG, 24'h00001a);
        run(12'h100, 12'h080);
        chk_samp("filt_a_out", 12'hf00, fa);
        chk_samp("filt_b_out", 12'h000, fb);
        wr(ADDR_CFG, 24'h0000da);
        run(12'h100, 12'h080);
        chk_samp("filt_b_out", 12'hf80, fb);
        run(12'h100, 12'h100);
        chk_samp("filt_b_out", 12'hf00, fb);
        $display("test center done");
        wr(ADDR_COEF[4], 24'h000000);
        wr(ADDR_COEF[1], 24'h000400);
        wr(ADDR_CFG, 24'h00003a);
        run(12'h111, 12'h222);
        chk_samp("filt_a_out", 12'h222, fa);
        chk_samp("filt_b_out", 12'h111, fb);
        $display("test merge done");
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(ADDR_CFG, 24'h000000);
        rd(ADDR_COEF[1], 24'h000000);
        $display("test rerun reset done");
        summarize();
    end
endmodule // programmable_fir_equalizer_cfg_test
